// ===== rtl/iacs_map.svh
`ifndef IACS_MAP_SVH
`define IACS_MAP_SVH

// Register byte addresses
`define IACS_A_RES_LSB 8'h50
`define IACS_A_RES_MSB 8'h51
`define IACS_A_CFG0 8'h52
`define IACS_A_CFG1 8'h53
`define IACS_A_CFG2 8'h54
`define IACS_A_CFG3 8'h55
`define IACS_A_CFG4 8'h56
`define IACS_A_SEQ 8'h58

// conv_config_0 fields
`define IACS_B_START 7
`define IACS_F_NELC 6:5
`define IACS_F_OSR 4:2
`define IACS_B_DEF 1
// Enable bit
`define IACS_B_EN 0
// conv_config_2 fields
`define IACS_F_FREQ 7:6
`define IACS_F_S2GAIN 5:4
`define IACS_F_S2OFF 3:0
// conv_config_3 fields
`define IACS_B_S1GAIN 7
`define IACS_F_S3GAIN 6:0
// conv_config_4 field
`define IACS_F_S3OFF 6:0
// Sequence control register
`define IACS_F_BGMODE 1:0
`define IACS_B_BUSY 7

// Reset values
`define IACS_RST_CFG0 8'h00
`define IACS_RST_CFG1 8'h00
`define IACS_RST_CFG2 8'h00
`define IACS_RST_CFG3 8'h00
`define IACS_RST_CFG4 8'h00
`define IACS_RST_BG 2'h0
`define IACS_RST_RESULT 16'h0000

// Bandgap modes
`define IACS_BG_LOW 2'h0
`define IACS_BG_HIGH 2'h1
`define IACS_BG_TOG1 2'h2
`define IACS_BG_TOG2 2'h3

// Timing and arithmetic
`define IACS_REF_MHZ 200
`define IACS_OSC_MHZ 4
`define IACS_OSC_PER_FS_MAX 12'h008
`define IACS_OSR_BASE 11'h008
`define IACS_OSR_EXP_BASE 5'h03
`define IACS_RES_BITS 5'h10
`define IACS_POS_FS 16'h7FFF
`define IACS_NEG_FS 16'h8000

`endif

// ===== rtl/iacs_pkg.sv
package iacs_pkg;

    typedef enum logic [1:0] {
        IACS_IDLE = 2'b00,
        IACS_ELEM = 2'b01,
        IACS_FINAL = 2'b10
    } iacs_state_e;

    typedef struct packed {
        logic [7:0] cfg0;
        logic [7:0] cfg1;
        logic [7:0] cfg2;
        logic [7:0] cfg3;
        logic [7:0] cfg4;
        logic [1:0] bg_mode;
        iacs_state_e st;
        logic [3:0] elem_idx;
        logic [10:0] per_cnt;
        logic signed [11:0] acc1;
        logic signed [21:0] acc2;
        logic signed [25:0] total;
        logic [15:0] result;
        logic [7:0] msb_shadow;
        logic [7:0] rd_data;
        logic bandgap;
        logic polarity;
        logic done;
        logic restart;
        logic active;
        logic shadow_pend;
    } iacs_main_s;

endpackage

// ===== rtl/iacs_sync.sv
`timescale 1ns/1ps
module iacs_sync #(
    parameter int W = 1
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // First stage feeds only the second stage
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else if (ce_i) begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule

// ===== rtl/iacs_os_tick.sv
`timescale 1ns/1ps
`include "iacs_map.svh"
module iacs_os_tick
    import iacs_pkg::*;
#(
    parameter int OSC_DIV = `IACS_REF_MHZ / `IACS_OSC_MHZ
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic clr_i,
    input wire logic [1:0] freq_sel_i,
    output logic tick_o
);
    localparam logic [5:0] OSC_DIV_W = 6'(OSC_DIV - 1);

    // Two-level divide keeps the 4 MHz phase separate from the fs divider
    logic [5:0] osc_cnt_q;
    logic [11:0] fs_cnt_q;
    logic tick_q;
    logic [11:0] fs_last;
    logic osc_tick;

    assign fs_last = (`IACS_OSC_PER_FS_MAX << (2'h3 - freq_sel_i)) - 12'h001;
    assign osc_tick = (osc_cnt_q == OSC_DIV_W);

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            osc_cnt_q <= '0;
            fs_cnt_q <= '0;
            tick_q <= 1'b0;
        end else if (ce_i) begin
            tick_q <= 1'b0;
            if (clr_i) begin
                osc_cnt_q <= '0;
                fs_cnt_q <= '0;
            end else if (osc_tick) begin
                osc_cnt_q <= '0;
                if (fs_cnt_q >= fs_last) begin
                    fs_cnt_q <= '0;
                    tick_q <= 1'b1;
                end else begin
                    fs_cnt_q <= fs_cnt_q + 12'h001;
                end
            end else begin
                osc_cnt_q <= osc_cnt_q + 6'h01;
            end
        end
    end

    assign tick_o = tick_q;
endmodule

// ===== rtl/iacs_seq.sv
// Notes on behaviour
// - Writing start or default-start bit launches a new conversion sequence.
// - Sequence is programmed count of elementary conversions then one final step.
// - Each elementary conversion lasts integration count plus one oversampling periods.
// - Result is the mean of all elementary conversion results.
// - Offset polarity flips between successive elementary conversions.
// - Bandgap control held low, high, or toggled per elementary or every two.
// - Oversampling tick derived from 4 MHz; selector picks 62.5 to 500 kHz.
// - Integration count is two to the power three plus ratio code.
// - Elementary count is two to the power of count code.
// - Resolution twice log2 integration plus log2 count, capped at 16.
// - Total time is count times integration plus one, plus one period.
// - Result is a 16-bit two's-complement word.
// - Out-of-range values clamp to positive or negative full scale.
// - Below 16 bits the non-significant low bits are forced.
// - Forced pattern is a single one followed by zeros.
// - Holds stage gain and offset words for the amplifier chain.
// - Enable bit gates converter activity.
`timescale 1ns/1ps
`include "iacs_map.svh"
module iacs_seq
    import iacs_pkg::*;
#(
    parameter int OSC_DIV = `IACS_REF_MHZ / `IACS_OSC_MHZ
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic mod_bit_i,
    output logic conv_enable_o,
    output logic conv_active_o,
    output logic conv_done_o,
    output logic offset_polarity_o,
    output logic bandgap_o,
    output logic stage1_gain_o,
    output logic [1:0] stage2_gain_o,
    output logic [3:0] stage2_offset_o,
    output logic [6:0] stage3_gain_o,
    output logic [6:0] stage3_offset_o
);
    iacs_main_s q;
    iacs_main_s d;
    logic mod_bit;
    logic os_tick;

    // Modulator bit comes from the analog domain
    iacs_sync #(
        .W(1)
    ) u_sync (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .async_i(mod_bit_i),
        .sync_o(mod_bit)
    );

    iacs_os_tick #(
        .OSC_DIV(OSC_DIV)
    ) u_tick (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .clr_i(q.restart),
        .freq_sel_i(q.cfg2[`IACS_F_FREQ]),
        .tick_o(os_tick)
    );

    function automatic logic [15:0] shape_result(
        input logic signed [25:0] total,
        input logic [2:0] osr_sel,
        input logic [1:0] nelc_sel
    );
        logic [4:0] n_raw;
        logic [4:0] forced;
        logic signed [31:0] wide;
        logic [15:0] word;
        logic [15:0] mask;
        n_raw = 5'((`IACS_OSR_EXP_BASE + 5'(osr_sel)) << 1) + 5'(nelc_sel);
        if (n_raw <= `IACS_RES_BITS) begin
            // Scaling by 2^(16-n) against a sum of N elements is the mean
            forced = `IACS_RES_BITS - n_raw;
            wide = 32'(total) <<< forced;
        end else begin
            forced = 5'h00;
            wide = 32'(total) >>> (n_raw - `IACS_RES_BITS);
        end
        if (wide > 32'sh00007FFF) begin
            word = `IACS_POS_FS;
        end else if (wide < -32'sh00008000) begin
            word = `IACS_NEG_FS;
        end else begin
            word = wide[15:0];
        end
        if (forced != 5'h00) begin
            mask = 16'hFFFF << forced;
            word = (word & mask) | (16'h0001 << (forced - 5'h01));
        end
        return word;
    endfunction

    always_comb begin
        logic start_req;
        logic [10:0] osr_last;
        logic [3:0] elem_last;
        logic signed [11:0] acc1_n;
        logic signed [21:0] acc2_n;
        logic signed [25:0] elem_val;
        logic bg_step;
        d = q;
        d.done = 1'b0;
        d.restart = 1'b0;
        start_req = 1'b0;
        osr_last = `IACS_OSR_BASE << q.cfg0[`IACS_F_OSR];
        elem_last = 4'((5'h01 << q.cfg0[`IACS_F_NELC]) - 5'h01);
        acc1_n = q.acc1 + (mod_bit ? 12'sh001 : -12'sh001);
        acc2_n = q.acc2 + 22'(acc1_n);
        // Polarity-compensated elementary value
        elem_val = q.polarity ? -26'(acc2_n) : 26'(acc2_n);
        bg_step = 1'b0;

        // Register writes
        if (wr_i) begin
            case (addr_i)
                `IACS_A_CFG0: begin
                    d.cfg0 = wdata_i;
                    d.cfg0[`IACS_B_START] = 1'b0;
                    d.cfg0[`IACS_B_DEF] = 1'b0;
                    start_req = wdata_i[`IACS_B_START] | wdata_i[`IACS_B_DEF];
                end
                `IACS_A_CFG1: d.cfg1 = wdata_i;
                `IACS_A_CFG2: d.cfg2 = wdata_i;
                `IACS_A_CFG3: d.cfg3 = wdata_i;
                `IACS_A_CFG4: d.cfg4 = wdata_i;
                `IACS_A_SEQ: d.bg_mode = wdata_i[`IACS_F_BGMODE];
                default: ;
            endcase
        end

        // Sequencer
        case (q.st)
            IACS_IDLE: begin
                d.per_cnt = '0;
            end
            IACS_ELEM: begin
                // A tick launched before the divider clear is stale
                if (os_tick && !q.restart) begin
                    // Ratio may change mid-run, so never step past the end
                    if (q.per_cnt >= osr_last) begin
                        d.total = q.total + elem_val;
                        d.acc1 = '0;
                        d.acc2 = '0;
                        d.per_cnt = '0;
                        bg_step = 1'b1;
                        if (q.elem_idx >= elem_last) begin
                            d.st = IACS_FINAL;
                        end else begin
                            d.elem_idx = q.elem_idx + 4'h1;
                            d.polarity = ~q.polarity;
                        end
                    end else begin
                        d.acc1 = acc1_n;
                        d.acc2 = acc2_n;
                        d.per_cnt = q.per_cnt + 11'h001;
                    end
                end
            end
            IACS_FINAL: begin
                // One extra oversampling period closes the sequence
                if (os_tick && !q.restart) begin
                    d.result = shape_result(q.total, q.cfg0[`IACS_F_OSR],
                                            q.cfg0[`IACS_F_NELC]);
                    d.done = 1'b1;
                    d.st = IACS_IDLE;
                end
            end
            default: d.st = IACS_IDLE;
        endcase

        // Bandgap control held low or high, or toggled at elementary boundaries
        case (q.bg_mode)
            `IACS_BG_LOW: d.bandgap = 1'b0;
            `IACS_BG_HIGH: d.bandgap = 1'b1;
            `IACS_BG_TOG1: begin
                if (bg_step) begin
                    d.bandgap = ~q.bandgap;
                end
            end
            `IACS_BG_TOG2: begin
                if (bg_step && q.elem_idx[0]) begin
                    d.bandgap = ~q.bandgap;
                end
            end
            default: d.bandgap = 1'b0;
        endcase

        // New start wins over any running sequence
        if (start_req) begin
            d.st = IACS_ELEM;
            d.elem_idx = '0;
            d.per_cnt = '0;
            d.acc1 = '0;
            d.acc2 = '0;
            d.total = '0;
            d.polarity = 1'b0;
            d.restart = 1'b1;
            if ((q.bg_mode == `IACS_BG_TOG1) || (q.bg_mode == `IACS_BG_TOG2)) begin
                d.bandgap = 1'b0;
            end
        end

        // Disabled converter stays idle and drops any sequence
        if (!d.cfg1[`IACS_B_EN]) begin
            d.st = IACS_IDLE;
            d.done = 1'b0;
            d.polarity = 1'b0;
            d.elem_idx = '0;
            d.per_cnt = '0;
            d.result = q.result;
        end
        // Registered so the busy port comes straight from a flop
        d.active = (d.st != IACS_IDLE);

        // Register reads; low byte read snapshots the high byte
        d.rd_data = 8'h00;
        if (rd_i) begin
            case (addr_i)
                `IACS_A_RES_LSB: begin
                    d.rd_data = q.result[7:0];
                    d.msb_shadow = q.result[15:8];
                    d.shadow_pend = 1'b1;
                end
                `IACS_A_RES_MSB: begin
                    d.rd_data = q.msb_shadow;
                    d.shadow_pend = 1'b0;
                end
                `IACS_A_CFG0: d.rd_data = q.cfg0;
                `IACS_A_CFG1: d.rd_data = q.cfg1;
                `IACS_A_CFG2: d.rd_data = q.cfg2;
                `IACS_A_CFG3: d.rd_data = q.cfg3;
                `IACS_A_CFG4: d.rd_data = q.cfg4;
                `IACS_A_SEQ: begin
                    d.rd_data[`IACS_F_BGMODE] = q.bg_mode;
                    d.rd_data[`IACS_B_BUSY] = (q.st != IACS_IDLE);
                end
                default: d.rd_data = 8'h00;
            endcase
        end
        // Shadow tracks the result when no low-byte read is pending
        if (d.done && !d.shadow_pend) begin
            d.msb_shadow = d.result[15:8];
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q.cfg0 <= `IACS_RST_CFG0;
            q.cfg1 <= `IACS_RST_CFG1;
            q.cfg2 <= `IACS_RST_CFG2;
            q.cfg3 <= `IACS_RST_CFG3;
            q.cfg4 <= `IACS_RST_CFG4;
            q.bg_mode <= `IACS_RST_BG;
            q.st <= IACS_IDLE;
            q.elem_idx <= '0;
            q.per_cnt <= '0;
            q.acc1 <= '0;
            q.acc2 <= '0;
            q.total <= '0;
            q.result <= `IACS_RST_RESULT;
            q.msb_shadow <= '0;
            q.rd_data <= '0;
            q.bandgap <= 1'b0;
            q.polarity <= 1'b0;
            q.done <= 1'b0;
            q.restart <= 1'b0;
            q.active <= 1'b0;
            q.shadow_pend <= 1'b0;
        end else if (ce_i) begin
            q <= d;
        end
    end

    assign rdata_o = q.rd_data;
    assign conv_enable_o = q.cfg1[`IACS_B_EN];
    assign conv_active_o = q.active;
    assign conv_done_o = q.done;
    assign offset_polarity_o = q.polarity;
    assign bandgap_o = q.bandgap;
    assign stage1_gain_o = q.cfg3[`IACS_B_S1GAIN];
    assign stage2_gain_o = q.cfg2[`IACS_F_S2GAIN];
    assign stage2_offset_o = q.cfg2[`IACS_F_S2OFF];
    assign stage3_gain_o = q.cfg3[`IACS_F_S3GAIN];
    assign stage3_offset_o = q.cfg4[`IACS_F_S3OFF];
endmodule

// ===== verification/iacs_seq_sva.sv
`timescale 1ns/1ps
module iacs_seq_chk (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic conv_enable_o,
    input wire logic conv_active_o,
    input wire logic conv_done_o,
    input wire logic offset_polarity_o,
    input wire logic bandgap_o,
    input wire logic stage1_gain_o,
    input wire logic [1:0] stage2_gain_o,
    input wire logic [3:0] stage2_offset_o,
    input wire logic [6:0] stage3_gain_o,
    input wire logic [6:0] stage3_offset_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    logic [1:0] bgm_q;
    // Mode field is not at the ports, so it is shadowed from the writes
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bgm_q <= 2'h0;
        end else if (wr_i && addr_i == 8'h58) begin
            bgm_q <= wdata_i[1:0];
        end
    end
    chk_start_runs: assert property (wr_i && addr_i == 8'h52 &&
        (wdata_i[7] || wdata_i[1]) && conv_enable_o |=> conv_active_o)
        else $error("start write did not launch a sequence");
    chk_en_gate: assert property (!conv_enable_o && !conv_active_o |=>
        !conv_active_o)
        else $error("sequence ran while disabled");
    chk_done_pulse: assert property (conv_done_o |=> !conv_done_o)
        else $error("done longer than one cycle");
    chk_done_end: assert property (conv_done_o |-> $past(conv_active_o))
        else $error("done without a running sequence");
    chk_pol_run: assert property ($changed(offset_polarity_o) |->
        conv_active_o || $past(conv_active_o))
        else $error("polarity moved while idle");
    chk_gain_words: assert property (wr_i && addr_i == 8'h55 |=>
        {stage1_gain_o, stage3_gain_o} == $past(wdata_i))
        else $error("gain word not taken");
    chk_s2_word: assert property (wr_i && addr_i == 8'h54 |=>
        {stage2_gain_o, stage2_offset_o} == $past(wdata_i[5:0]))
        else $error("second stage word not taken");
    chk_s3_offset: assert property (wr_i && addr_i == 8'h56 |=>
        stage3_offset_o == $past(wdata_i[6:0]))
        else $error("third stage offset not taken");
    chk_bg_fixed: assert property (!bgm_q[1] && $stable(bgm_q) |->
        bandgap_o == bgm_q[0])
        else $error("bandgap not at held level");
endmodule

bind iacs_seq iacs_seq_chk chk_u (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .conv_enable_o(conv_enable_o), .conv_active_o(conv_active_o),
    .conv_done_o(conv_done_o), .offset_polarity_o(offset_polarity_o),
    .bandgap_o(bandgap_o), .stage1_gain_o(stage1_gain_o), .stage2_gain_o(stage2_gain_o),
    .stage2_offset_o(stage2_offset_o), .stage3_gain_o(stage3_gain_o),
    .stage3_offset_o(stage3_offset_o)
);

// ===== verification/iacs_mod_model.sv
`timescale 1ns/1ps
module iacs_mod_model (
    input wire logic level_i,
    input wire logic polarity_i,
    output logic mod_bit_o
);
    // Chopped input flips with polarity, so every pass yields the same value
    assign mod_bit_o = level_i ^ polarity_i;
endmodule

// ===== verification/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic rd_q = 1'b0;
    logic lvl = 1'b1;
    logic ce = 1'b1;
    logic mod_bit, en, act, done, pol, bg, s1g, bp;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic [7:0] rdata_o, d0, d1, d2;
    logic [1:0] s2g;
    logic [3:0] s2o;
    logic [6:0] s3g, s3o;
    logic [15:0] lfsr = 16'h7741;
    logic [7:0] expq[$];
    logic [7:0] md[4] = '{8'h00, 8'h03, 8'h02, 8'h01};
    int nt[4] = '{0, 2, 4, 0};
    int failures = 0;
    int compares = 0;
    int cyc = 0;
    int tg;
    // Short divider keeps the longest run well inside the cycle budget
    iacs_seq #(.OSC_DIV(2)) dut_u (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ce_i(ce), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .mod_bit_i(mod_bit),
        .conv_enable_o(en), .conv_active_o(act), .conv_done_o(done),
        .offset_polarity_o(pol), .bandgap_o(bg), .stage1_gain_o(s1g), .stage2_gain_o(s2g),
        .stage2_offset_o(s2o), .stage3_gain_o(s3g), .stage3_offset_o(s3o)
    );
    iacs_mod_model mod_u (.level_i(lvl), .polarity_i(pol), .mod_bit_o(mod_bit));
    initial begin
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end
    task automatic tally_and_finish();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %04h expected %04h", $time, got, exp);
        end
    endtask
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 70000) begin
            failures++;
            tally_and_finish();
        end
        if (rd_q) begin
            check({8'h00, rdata_o}, {8'h00, expq.pop_front()});
        end
        rd_q <= rd_i;
    end
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Strobes are left up between calls; idle drops them
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        wr_i <= w;
        rd_i <= !w;
        addr_i <= a;
        wdata_i <= d;
        @(posedge ref_clk_i);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        expq.push_back(e);
        bus(1'b0, a, 8'h00);
    endtask
    task automatic idle(input int n);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        repeat (n) @(posedge ref_clk_i);
    endtask
    task automatic conv(input logic [1:0] f, input logic [2:0] r, input logic [1:0] c,
            input logic l, input logic [7:0] sb);
        int k;
        int t0;
        int per;
        int ticks;
        int el;
        int tp;
        logic pp;
        logic [15:0] e;
        per = 2 * (8 << (3 - f));
        ticks = (1 << c) * ((8 << r) + 1) + 1;
        k = 16 - (2 * (3 + r) + c);
        e = l ? 16'h7FFF : 16'h8000;
        if (k > 0) begin
            e = (e & ~((16'h0001 << k) - 16'h0001)) | (16'h0001 << (k - 1));
        end
        lvl <= l;
        bus(1'b1, 8'h54, {f, 6'h00});
        bus(1'b1, 8'h52, {1'b0, c, r, 2'b00} | sb);
        idle(1);
        t0 = cyc;
        bp = bg;
        pp = pol;
        tg = 0;
        tp = 0;
        while (done !== 1'b1 && cyc - t0 < 20000) begin
            @(posedge ref_clk_i);
            tg += (bg !== bp);
            tp += (pol !== pp);
            bp = bg;
            pp = pol;
        end
        // Start edge, divider clear and registered done add a few cycles
        el = cyc - t0 - ticks * per;
        check({15'h0000, el >= 0 && el <= 4}, 16'h0001);
        check(tp[15:0], 16'((1 << c) - 1));
        rd(8'h50, e[7:0]);
        rd(8'h51, e[15:8]);
        idle(2);
    endtask
    initial begin
        repeat (2) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        for (int a = 8'h50; a < 8'h59; a++) begin
            rd(a[7:0], 8'h00);
        end
        rd(8'hA5, 8'h00);
        idle(2);
        check({15'h0000, en}, 16'h0000);
        $display("test reset values done");
        for (int i = 0; i < 4; i++) begin
            lfsr = lfsr_next(lfsr);
            d0 = lfsr[7:0];
            d1 = lfsr[15:8];
            lfsr = lfsr_next(lfsr);
            d2 = lfsr[7:0];
            bus(1'b1, 8'h54, d0);
            bus(1'b1, 8'h55, d1);
            bus(1'b1, 8'h56, d2);
            bus(1'b1, 8'h52, d2 & 8'h7D);
            rd(8'h54, d0);
            rd(8'h55, d1);
            rd(8'h56, d2);
            rd(8'h52, d2 & 8'h7D);
            idle(1);
            check({s1g, s3g, s3o, 1'b0}, {d1, d2[6:0], 1'b0});
            check({10'h000, s2g, s2o}, {10'h000, d0[5:0]});
        end
        bus(1'b1, 8'h52, 8'h82);
        idle(20);
        check({15'h0000, act}, 16'h0000);
        // Write with the clock enable low is lost
        ce <= 1'b0;
        bus(1'b1, 8'h53, 8'h01);
        ce <= 1'b1;
        idle(1);
        check({15'h0000, en}, 16'h0000);
        bus(1'b1, 8'h53, 8'h01);
        idle(1);
        check({15'h0000, en}, 16'h0001);
        $display("test registers done");
        conv(2'h3, 3'h0, 2'h0, 1'b1, 8'h80);
        conv(2'h3, 3'h0, 2'h0, 1'b0, 8'h02);
        conv(2'h3, 3'h0, 2'h1, 1'b1, 8'h80);
        conv(2'h2, 3'h1, 2'h3, 1'b0, 8'h02);
        conv(2'h1, 3'h0, 2'h3, 1'b1, 8'h80);
        conv(2'h0, 3'h0, 2'h2, 1'b0, 8'h80);
        for (int r = 2; r < 8; r++) begin
            conv(2'h3, r[2:0], 2'h0, r[0], 8'h80);
        end
        $display("test conversions done");
        bus(1'b1, 8'h52, 8'h84);
        idle(40);
        rd(8'h58, 8'h80);
        conv(2'h3, 3'h1, 2'h0, 1'b1, 8'h80);
        $display("test restart done");
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, 8'h58, md[m]);
            conv(2'h3, 3'h0, 2'h2, 1'b1, 8'h80);
            check(16'(tg), 16'(nt[m]));
        end
        $display("test bandgap modes done");
        tally_and_finish();
    end
endmodule
